// *** src/ptbw_pkg.sv ***
// Package: constants and types shared by both ends of the burst write pass-through port
// Summary of operation
// - Capture start address, store each data phase
// - Address holder advances as burst proceeds
// - Posted writes off: one word, then hold
// - No burst flag while write FIFO disabled
// - Status outputs update edge after recognition
// - Status valid only while access pending
// - Pending, burst, region, direction, byte lanes driven
// - Fetch strobe reads address, latched next edge
// - Pipelined read: data one clock later
// - Phase done completes phase, advances lanes
// - Burst flag drops with one phase left
// - Final phase done drops pending, data stays
// - Add-on releases strobes after last read
// - New access may start next clock
// - Phase done deasserted means wait state
// - Non-burst add-on pulses fetch around reads
// - Held read strobe keeps bus driven
// - Continuous phase done moves word per clock
// - Data port sits at offset 2Ch
// - Release bus unless read selected last cycle or fetch strobe asserted
// - Never write strobe with fetch strobe
package ptbw_pkg;
  // ==========================================================
  // Register map
  localparam logic [6:0] PTBW_DATA_PORT_OFS = 7'h2C;
  localparam logic [4:0] PTBW_DATA_PORT_IDX = PTBW_DATA_PORT_OFS[6:2];
  // ==========================================================
  // Reset values
  localparam logic [3:0] PTBW_LANES_RST = 4'hF;
  localparam logic [1:0] PTBW_REGION_RST = 2'h0;
  localparam logic [31:0] PTBW_ADDR_RST = 32'h0000_0000;
  localparam logic [4:0] PTBW_CNT_RST = 5'h00;
  // Address step per 32-bit data phase
  localparam logic [31:0] PTBW_ADDR_STEP = 32'h0000_0004;
  localparam logic [4:0] PTBW_ONE = 5'h01;
  // ==========================================================
  // Host-side states
  typedef enum logic [1:0] {PTBW_H_IDLE, PTBW_H_ADDR, PTBW_H_READ, PTBW_H_LAST} ptbw_host_e;
endpackage

// *** src/ptbw_if.sv ***
// Interface: add-on bus between the pass-through port and add-on logic
`timescale 1ns/1ps
`default_nettype none
interface ptbw_if;
  logic accessPendingN;
  logic multiPhaseFlagN;
  logic [1:0] regionIndex;
  logic directionIsWrite;
  logic [3:0] pendingByteLanesN;
  logic addressFetchStrobeN;
  logic phaseDoneN;
  logic readStrobeN;
  logic writeStrobeN;
  logic selectN;
  logic [3:0] registerByteLanesN;
  logic [6:2] wordAddr;
  logic [31:0] dqDev;
  logic dqDevOe;
  logic [31:0] dqHost;
  logic dqHostOe;
  modport device (
    output accessPendingN, multiPhaseFlagN, regionIndex, directionIsWrite,
    output pendingByteLanesN, dqDev, dqDevOe,
    input addressFetchStrobeN, phaseDoneN, readStrobeN, writeStrobeN, selectN,
    input registerByteLanesN, wordAddr, dqHost, dqHostOe
  );
  modport host (
    input accessPendingN, multiPhaseFlagN, regionIndex, directionIsWrite,
    input pendingByteLanesN, dqDev, dqDevOe,
    output addressFetchStrobeN, phaseDoneN, readStrobeN, writeStrobeN, selectN,
    output registerByteLanesN, wordAddr, dqHost, dqHostOe
  );
endinterface
`default_nettype wire

// *** src/ptbw_device.sv ***
// Device end: captures a PCI burst write and presents it to add-on logic
`timescale 1ns/1ps
`default_nettype none
module ptbw_device
  import ptbw_pkg::*;
#(
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic clk,
  input wire logic rst_b,
  // PCI-side capture port
  input wire logic pciStart,
  input wire logic [31:0] pciAddr,
  input wire logic [1:0] pciRegion,
  input wire logic pciData,
  input wire logic [31:0] pciWord,
  input wire logic [3:0] pciLanesN,
  input wire logic pciLast,
  input wire logic postedEnable,
  output logic pciReady,
  output logic [31:0] addrNow,
  ptbw_if.device bus
);
  typedef struct packed {
    logic pending;
    logic capturing;
    logic [AW:0] wrPtr;
    logic [AW:0] rdPtr;
    logic [4:0] phasesLeft;
    logic [1:0] region;
    logic [31:0] addrHold;
    logic [31:0] dq;
    logic dqOe;
  } ptbw_dev_s;

  ptbw_dev_s st;
  ptbw_dev_s next_st;
  logic [31:0] dataMem [DEPTH];
  logic [3:0] laneMem [DEPTH];
  logic [AW:0] used;
  logic full;
  logic phaseDone;
  logic readHit;

  // ==========================================================
  // Capture side
  assign used = st.wrPtr - st.rdPtr;
  // Posted mode fills every slot; otherwise one word at a time
  assign full = postedEnable ? (used == (AW+1)'(DEPTH)) : (used != '0);
  assign pciReady = !full && (st.capturing || !st.pending);
  assign phaseDone = st.pending && !bus.phaseDoneN && (used != '0);
  assign readHit = !bus.readStrobeN && !bus.selectN && (bus.wordAddr == PTBW_DATA_PORT_IDX);

  always_ff @(posedge clk) begin
    if (pciData && pciReady) begin
      dataMem[st.wrPtr[AW-1:0]] <= pciWord;
      laneMem[st.wrPtr[AW-1:0]] <= pciLanesN;
    end
  end

  always_comb begin
    next_st = st;
    if (pciStart && !st.pending) begin
      next_st.addrHold = pciAddr;
      next_st.region = pciRegion;
      next_st.capturing = 1'b1;
      next_st.pending = 1'b1;
      next_st.phasesLeft = PTBW_CNT_RST;
    end
    if (pciData && pciReady) begin
      next_st.wrPtr = st.wrPtr + (AW+1)'(1);
      next_st.phasesLeft = next_st.phasesLeft + PTBW_ONE;
      if (!(pciStart && !st.pending)) begin
        next_st.addrHold = st.addrHold + PTBW_ADDR_STEP;
      end
      if (pciLast) begin
        next_st.capturing = 1'b0;
      end
    end
    if (phaseDone) begin
      next_st.rdPtr = st.rdPtr + (AW+1)'(1);
      next_st.phasesLeft = next_st.phasesLeft - PTBW_ONE;
      if (st.phasesLeft == PTBW_ONE && !st.capturing) begin
        next_st.pending = 1'b0;
      end
    end
    // Data driven one clock after a sampled read; address fetch bypasses the pipe
    next_st.dqOe = readHit;
    if (readHit) begin
      next_st.dq = dataMem[st.rdPtr[AW-1:0]];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '{pending: 1'b0, capturing: 1'b0, wrPtr: '0, rdPtr: '0,
              phasesLeft: PTBW_CNT_RST, region: PTBW_REGION_RST,
              addrHold: PTBW_ADDR_RST, dq: 32'h0000_0000, dqOe: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Add-on status outputs
  assign bus.accessPendingN = !st.pending;
  // Burst flag needs posting enabled and either capture still running or more than one phase left
  assign bus.multiPhaseFlagN = !(st.pending && postedEnable &&
                                 (st.capturing || st.phasesLeft > PTBW_ONE));
  assign bus.regionIndex = st.region;
  assign bus.directionIsWrite = st.pending;
  assign bus.pendingByteLanesN = (used != '0) ? laneMem[st.rdPtr[AW-1:0]] : PTBW_LANES_RST;
  assign bus.dqDev = !bus.addressFetchStrobeN ? st.addrHold : st.dq;
  assign bus.dqDevOe = !bus.addressFetchStrobeN || st.dqOe;
  assign addrNow = st.addrHold;
endmodule // ptbw_device
`default_nettype wire

// *** src/ptbw_host.sv ***
// Host end: add-on logic draining the pass-through burst write
`timescale 1ns/1ps
`default_nettype none
module ptbw_host
  import ptbw_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic userReady,
  output logic userValid,
  output logic [31:0] userData,
  output logic [31:0] userAddr,
  output logic userAddrValid,
  ptbw_if.host bus
);
  typedef struct packed {
    ptbw_host_e state;
    logic rdPend;
    logic [31:0] data;
    logic valid;
    logic [31:0] addr;
    logic addrValid;
  } ptbw_host_s;

  ptbw_host_s st;
  ptbw_host_s next_st;
  logic reading;

  // Only read when the sink can take a word, else wait states
  assign reading = userReady && (st.state == PTBW_H_READ);

  always_comb begin
    next_st = st;
    next_st.valid = 1'b0;
    next_st.addrValid = 1'b0;
    next_st.rdPend = reading;
    if (st.rdPend) begin
      next_st.data = bus.dqDev;
      next_st.valid = 1'b1;
    end
    unique case (st.state)
      PTBW_H_IDLE: if (!bus.accessPendingN) next_st.state = PTBW_H_ADDR;
      PTBW_H_ADDR: begin
        next_st.addr = bus.dqDev;
        next_st.addrValid = 1'b1;
        next_st.state = PTBW_H_READ;
      end
      PTBW_H_READ: if (reading && bus.multiPhaseFlagN) next_st.state = PTBW_H_LAST;
      PTBW_H_LAST: next_st.state = PTBW_H_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '{state: PTBW_H_IDLE, rdPend: 1'b0, data: 32'h0000_0000, valid: 1'b0,
              addr: 32'h0000_0000, addrValid: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign bus.addressFetchStrobeN = !(st.state == PTBW_H_ADDR);
  assign bus.writeStrobeN = 1'b1;
  assign bus.readStrobeN = !reading;
  assign bus.selectN = !reading;
  assign bus.phaseDoneN = !reading;
  assign bus.registerByteLanesN = reading ? 4'h0 : 4'hF;
  assign bus.wordAddr = PTBW_DATA_PORT_IDX;
  assign bus.dqHost = 32'h0000_0000;
  assign bus.dqHostOe = 1'b0;
  assign userValid = st.valid;
  assign userData = st.data;
  assign userAddr = st.addr;
  assign userAddrValid = st.addrValid;
endmodule // ptbw_host
`default_nettype wire

// *** bench/ptbw_props.sv ***
// Checker: timing relations on the pass-through add-on bus
`timescale 1ns/1ps
`default_nettype none
module ptbw_props
  import ptbw_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic accessPendingN,
  input wire logic multiPhaseFlagN,
  input wire logic [1:0] regionIndex,
  input wire logic directionIsWrite,
  input wire logic addressFetchStrobeN,
  input wire logic phaseDoneN,
  input wire logic readStrobeN,
  input wire logic writeStrobeN,
  input wire logic selectN,
  input wire logic [6:2] wordAddr,
  input wire logic dqDevOe
);
  // ====
  // Sequences
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence dataRead;
    !readStrobeN && !selectN && wordAddr == PTBW_DATA_PORT_IDX;
  endsequence
  sequence lastPhase;
    !accessPendingN && !phaseDoneN ##1 accessPendingN;
  endsequence
  // ====
  // Assertions
  reset_idle_a: assert property (!$past(rst_b) |-> accessPendingN && multiPhaseFlagN && !dqDevOe)
    else $error("busy after reset");
  read_answer_a: assert property (dataRead |=> dqDevOe) else $error("no read data");
  bus_release_a: assert property (dqDevOe |-> !addressFetchStrobeN
    || (!$past(readStrobeN) && !$past(selectN))) else $error("bus driven unasked");
  fetch_drive_a: assert property (!addressFetchStrobeN |-> dqDevOe && writeStrobeN)
    else $error("fetch fault");
  last_word_a: assert property (lastPhase |-> dqDevOe && $past(multiPhaseFlagN))
    else $error("last phase fault");
  wait_state_a: assert property (!accessPendingN && phaseDoneN |=> !accessPendingN)
    else $error("phase ended in wait");
  status_gate_a: assert property (!multiPhaseFlagN || directionIsWrite |-> !accessPendingN)
    else $error("status while idle");
  status_hold_a: assert property (!accessPendingN [*2] |-> $stable(regionIndex))
    else $error("region moved");
endmodule // ptbw_props
`default_nettype wire

// *** bench/tb_passthru_burst_write_port.sv ***
// Testbench: both ends joined, random PCI bursts drained and compared
`timescale 1ns/1ps
`default_nettype none
module tb_passthru_burst_write_port
  import ptbw_pkg::*;
;
  logic clk = 0, rst_b = 0, pciStart = 0, pciData = 0, pciLast = 0;
  logic postedEnable = 1, userReady = 0, hold = 0;
  logic [31:0] pciAddr = 0, pciWord = 0, startAddr = 0, w, ofs, seed = 32'h0000_002C;
  logic [1:0] pciRegion = 0;
  logic [3:0] pciLanesN = 4'hF;
  logic pciReady, userValid, userAddrValid;
  logic [31:0] addrNow, userData, userAddr;
  logic [31:0] expQ[$];
  int mismatches = 0, num_checks = 0, n = 1, k, i;
  ptbw_if bus ();
  always #4 clk = ~clk;
  ptbw_device ptbw_device_i (.clk(clk), .rst_b(rst_b), .pciStart(pciStart), .pciAddr(pciAddr),
    .pciRegion(pciRegion), .pciData(pciData), .pciWord(pciWord), .pciLanesN(pciLanesN),
    .pciLast(pciLast), .postedEnable(postedEnable), .pciReady(pciReady), .addrNow(addrNow),
    .bus(bus));
  ptbw_host ptbw_host_i (.clk(clk), .rst_b(rst_b), .userReady(userReady), .userValid(userValid),
    .userData(userData), .userAddr(userAddr), .userAddrValid(userAddrValid), .bus(bus));
  ptbw_props ptbw_props_i (.clk(clk), .rst_b(rst_b), .accessPendingN(bus.accessPendingN),
    .multiPhaseFlagN(bus.multiPhaseFlagN), .regionIndex(bus.regionIndex),
    .directionIsWrite(bus.directionIsWrite), .addressFetchStrobeN(bus.addressFetchStrobeN),
    .phaseDoneN(bus.phaseDoneN), .readStrobeN(bus.readStrobeN), .writeStrobeN(bus.writeStrobeN),
    .selectN(bus.selectN), .wordAddr(bus.wordAddr), .dqDevOe(bus.dqDevOe));
  // ====
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] endAddr(input logic [31:0] a, input int cnt);
    return a + PTBW_ADDR_STEP * cnt;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (mismatches == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ====
  // Monitor; random ready gives wait states
  always @(posedge clk) begin
    userReady <= hold | ((rnd() & 32'h0000_0001) != 0);
    if (userValid) check(userData, expQ.pop_front());
    if (userAddrValid) begin
      ofs = userAddr - startAddr;
      check(32'(ofs <= endAddr(32'h0000_0000, n) && ofs[1:0] == 2'h0), 1);
    end
    if (!bus.accessPendingN)
      check(32'({bus.regionIndex, bus.directionIsWrite, postedEnable | bus.multiPhaseFlagN}),
        32'({pciRegion, 2'h3}));
  end
  // ====
  // Bursts: single, full depth, overfull, then random
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1;
    @(posedge clk);
    check(32'({bus.accessPendingN, bus.multiPhaseFlagN, bus.dqDevOe}), 32'h0000_0006);
    for (k = 0; k < 12; k++) begin
      n = k == 0 ? 1 : k == 1 ? 8 : k == 2 ? 10 : 1 + rnd() % 8;
      hold <= k == 1;
      postedEnable <= k != 3 && k != 7;
      pciRegion <= k[1:0];
      startAddr = rnd() & 32'hFFFF_FFF0;
      pciAddr <= startAddr;
      for (i = 0; i < n; i++) begin
        w = rnd();
        pciStart <= i == 0;
        pciData <= 1;
        pciWord <= w;
        pciLanesN <= 4'(rnd());
        pciLast <= i == n - 1;
        // Ready is combinational from state, so it is only trusted once settled
        @(negedge clk);
        while (!pciReady) @(negedge clk);
        if (!postedEnable) check(32'(expQ.size() < 2), 1);
        expQ.push_back(w);
        @(posedge clk);
      end
      pciData <= 0;
      pciStart <= 0;
      pciLast <= 0;
      for (i = 0; i < 300 && expQ.size() > 0; i++) @(posedge clk);
      check(32'(expQ.size()), 0);
      check(32'(bus.accessPendingN), 1);
      check(addrNow, endAddr(startAddr, n - 1));
      repeat (3) @(posedge clk);
    end
    print_verdict();
  end
  initial begin
    #400000;
    mismatches++;
    print_verdict();
  end
endmodule // tb_passthru_burst_write_port
`default_nettype wire
